/* hw/adcr_ctrl.sv */
// Converter control: result registers, byte-wise read, scan sequencing, end flag.
// Assumes a same-clock 8-bit register bus and an analog front end on code_in.
module adcr_ctrl #(
  parameter int unsigned CONV_CYC = adcr_pkg::CONV_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [adcr_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [adcr_pkg::BUS_W-1:0] bus_wdata,
  output logic [adcr_pkg::BUS_W-1:0] bus_rdata,
  input wire logic eight_bit_timer_trig,
  input wire logic ext_conv_trigger_n,
  input wire logic standby_req,
  input wire logic [adcr_pkg::CODE_W-1:0] code_in,
  output logic [adcr_pkg::CH_W-1:0] input_sel,
  output logic conv_end_irq
);

  typedef struct packed {
    adcr_pkg::adcr_csr_s csr;
    adcr_pkg::adcr_trig_e trig;
    logic flag_seen;
    logic [adcr_pkg::NUM_RES-1:0][adcr_pkg::CODE_W-1:0] res;
    logic [adcr_pkg::BUS_W-1:0] temp;
    logic [adcr_pkg::CH_W-1:0] cur;
    logic go;
    logic issued;
    logic abort;
    logic [adcr_pkg::BUS_W-1:0] rdata;
    logic irq;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
  } adcr_ctrl_s;

  adcr_ctrl_s s_r;
  adcr_ctrl_s s_nxt;
  adcr_pkg::adcr_bus_req_s req;

  logic tmr_busy;
  logic tmr_done;
  logic [adcr_pkg::CODE_W-1:0] tmr_code;

  // Left-aligned 16-bit view of a stored code with zero padding below.
  function automatic logic [15:0] res_word(input logic [adcr_pkg::CODE_W-1:0] code);
    res_word = {code, {adcr_pkg::RES_PAD_W{1'b0}}};
  endfunction

  // First input of a conversion: the selected one, or the group base in scan.
  function automatic logic [adcr_pkg::CH_W-1:0] first_ch(
    input logic scan,
    input logic [adcr_pkg::CH_W-1:0] ch
  );
    first_ch = scan ? {ch[2], 2'b00} : ch;
  endfunction

  // Control/status register packed into its byte.
  function automatic logic [adcr_pkg::BUS_W-1:0] csr_byte(input adcr_pkg::adcr_csr_s c);
    logic [adcr_pkg::BUS_W-1:0] b;
    b = adcr_pkg::BYTE_ZERO;
    b[adcr_pkg::CSR_FLAG_BIT] = c.conv_end_flag;
    b[adcr_pkg::CSR_IE_BIT] = c.conv_end_irq_enable;
    b[adcr_pkg::CSR_START_BIT] = c.conv_start_bit;
    b[adcr_pkg::CSR_SCAN_BIT] = c.scan;
    b[adcr_pkg::CSR_CH_LSB +: adcr_pkg::CH_W] = c.ch;
    csr_byte = b;
  endfunction

  assign req.rd = bus_rd;
  assign req.wr = bus_wr;
  assign req.addr = bus_addr;
  assign req.wdata = bus_wdata;

  adcr_conv_timer #(
    .CONV_CYC(CONV_CYC)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(s_r.go),
    .abort(s_r.abort),
    .code_in(code_in),
    .busy(tmr_busy),
    .done(tmr_done),
    .code(tmr_code)
  );

  always_comb begin
    logic ext_edge;
    logic hw_trig;
    logic start_req;
    logic flag_set;
    logic flag_clr;
    logic [1:0] slot;
    logic [adcr_pkg::CH_W-1:0] last;
    logic [15:0] word;
    ext_edge = 1'b0;
    hw_trig = 1'b0;
    start_req = 1'b0;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    slot = 2'b00;
    last = adcr_pkg::CH_ZERO;
    word = 16'h0000;
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.abort = 1'b0;

    // Two-stage synchroniser on the pin, then a falling-edge detect.
    s_nxt.ext_s1 = ext_conv_trigger_n;
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_s3 = s_r.ext_s2;
    ext_edge = s_r.ext_s3 && !s_r.ext_s2;

    // Hardware start sources as selected.
    hw_trig = ((s_r.trig == adcr_pkg::ADCR_TRIG_TIMER) && eight_bit_timer_trig) ||
              ((s_r.trig == adcr_pkg::ADCR_TRIG_EXT) && ext_edge);

    // Register reads, answered from a flip-flop one cycle later.
    if (req.rd) begin
      slot = req.addr[2:1];
      word = res_word(s_r.res[slot]);
      if (req.addr <= adcr_pkg::OFS_RES_LAST_LO) begin
        if (!req.addr[0]) begin
          s_nxt.rdata = word[15:8];
          s_nxt.temp = word[7:0];
        end else begin
          s_nxt.rdata = s_r.temp;
        end
      end else if (req.addr == adcr_pkg::OFS_CSR) begin
        s_nxt.rdata = csr_byte(s_r.csr);
        if (s_r.csr.conv_end_flag) begin
          s_nxt.flag_seen = 1'b1;
        end
      end else if (req.addr == adcr_pkg::OFS_TRIG_SEL) begin
        s_nxt.rdata = adcr_pkg::BYTE_ZERO;
        s_nxt.rdata[adcr_pkg::TRIG_SEL_LSB +: 2] = s_r.trig;
      end else begin
        s_nxt.rdata = adcr_pkg::BYTE_ZERO;
      end
    end

    // Register writes; result registers ignore writes.
    if (req.wr) begin
      if (req.addr == adcr_pkg::OFS_CSR) begin
        s_nxt.csr.conv_end_irq_enable = req.wdata[adcr_pkg::CSR_IE_BIT];
        s_nxt.csr.scan = req.wdata[adcr_pkg::CSR_SCAN_BIT];
        s_nxt.csr.ch = req.wdata[adcr_pkg::CSR_CH_LSB +: adcr_pkg::CH_W];
        s_nxt.csr.conv_start_bit = req.wdata[adcr_pkg::CSR_START_BIT];
        start_req = req.wdata[adcr_pkg::CSR_START_BIT];
        if (!req.wdata[adcr_pkg::CSR_FLAG_BIT] && s_r.flag_seen) begin
          flag_clr = 1'b1;
        end
      end else if (req.addr == adcr_pkg::OFS_TRIG_SEL) begin
        s_nxt.trig = adcr_pkg::adcr_trig_e'(req.wdata[adcr_pkg::TRIG_SEL_LSB +: 2]);
      end
    end

    if (hw_trig) begin
      s_nxt.csr.conv_start_bit = 1'b1;
      start_req = 1'b1;
    end

    // A fresh start loads the first input of the conversion.
    if (start_req && !s_r.csr.conv_start_bit) begin
      s_nxt.cur = first_ch(s_nxt.csr.scan, s_nxt.csr.ch);
    end

    // Standby ends any conversion.
    if (standby_req) begin
      s_nxt.csr.conv_start_bit = 1'b0;
    end

    // Conversion end: store the code, then advance or stop.
    last = s_r.csr.ch;
    if (tmr_done && s_r.issued) begin
      s_nxt.issued = 1'b0;
      s_nxt.res[s_r.cur[1:0]] = tmr_code;
      if (!s_r.csr.scan) begin
        flag_set = 1'b1;
        s_nxt.csr.conv_start_bit = 1'b0;
      end else if (s_r.cur == last) begin
        flag_set = 1'b1;
        s_nxt.cur = first_ch(s_r.csr.scan, s_r.csr.ch);
      end else begin
        s_nxt.cur = s_r.cur + 3'h1;
      end
    end else if (s_r.issued && !s_r.csr.conv_start_bit) begin
      s_nxt.abort = 1'b1;
      s_nxt.issued = 1'b0;
    end else if (s_r.csr.conv_start_bit && !s_r.issued && !tmr_busy) begin
      s_nxt.go = 1'b1;
      s_nxt.issued = 1'b1;
    end

    // Flag update: a set in the same cycle as a clear wins.
    if (flag_set) begin
      s_nxt.csr.conv_end_flag = 1'b1;
      s_nxt.flag_seen = 1'b0;
    end else if (flag_clr) begin
      s_nxt.csr.conv_end_flag = 1'b0;
      s_nxt.flag_seen = 1'b0;
    end

    s_nxt.irq = s_nxt.csr.conv_end_flag && s_nxt.csr.conv_end_irq_enable;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.trig <= adcr_pkg::ADCR_TRIG_SW_ONLY;
      s_r.ext_s1 <= 1'b1;
      s_r.ext_s2 <= 1'b1;
      s_r.ext_s3 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata = s_r.rdata;
  assign input_sel = s_r.cur;
  assign conv_end_irq = s_r.irq;

endmodule

/* hw/adcr_pkg.sv */
// Constants, register map and carrier types of the converter control block.
// Assumes a single 125 MHz clock and an 8-bit processor register bus.
package adcr_pkg;

  // Width of one conversion code and of the processor data bus.
  localparam int unsigned CODE_W = 10;
  localparam int unsigned BUS_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned NUM_RES = 4;

  // Conversion time of one channel, 8.06 us, and the system clock period.
  localparam int unsigned CONV_TIME_NS = 8060;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Byte offsets on the register bus.
  localparam logic [ADDR_W-1:0] OFS_RES_FIRST_HI = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RES_LAST_LO = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_CSR = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_TRIG_SEL = 4'h9;

  // Field positions of the control/status register.
  localparam int unsigned CSR_FLAG_BIT = 7;
  localparam int unsigned CSR_IE_BIT = 6;
  localparam int unsigned CSR_START_BIT = 5;
  localparam int unsigned CSR_SCAN_BIT = 4;
  localparam int unsigned CSR_CH_LSB = 0;
  localparam int unsigned CH_W = 3;

  // Field position of the trigger select bits.
  localparam int unsigned TRIG_SEL_LSB = 6;

  // Number of zero bits below a left-aligned code.
  localparam int unsigned RES_PAD_W = 16 - CODE_W;

  // Reset values.
  localparam logic [BUS_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
  localparam logic [CH_W-1:0] CH_ZERO = 3'h0;

  // Start sources that may launch a conversion besides software.
  typedef enum logic [1:0] {
    ADCR_TRIG_SW_ONLY = 2'b00,
    ADCR_TRIG_TIMER = 2'b01,
    ADCR_TRIG_EXT = 2'b10,
    ADCR_TRIG_NONE = 2'b11
  } adcr_trig_e;

  // Software view of the control/status register.
  typedef struct packed {
    logic conv_end_flag;
    logic conv_end_irq_enable;
    logic conv_start_bit;
    logic scan;
    logic [CH_W-1:0] ch;
  } adcr_csr_s;

  // Processor register access.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [BUS_W-1:0] wdata;
  } adcr_bus_req_s;

endpackage

/* hw/adcr_conv_timer.sv */
// Times one channel conversion and captures the code from the analog front end.
// Assumes the front end presents a settled code on code_in when done fires.
module adcr_conv_timer #(
  parameter int unsigned CONV_CYC = adcr_pkg::CONV_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic abort,
  input wire logic [adcr_pkg::CODE_W-1:0] code_in,
  output logic busy,
  output logic done,
  output logic [adcr_pkg::CODE_W-1:0] code
);

  localparam int unsigned CNT_W = $clog2(CONV_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
    logic [adcr_pkg::CODE_W-1:0] code;
  } adcr_tmr_s;

  adcr_tmr_s s_r;
  adcr_tmr_s s_nxt;

  // Counts the conversion period and raises done for one cycle at its end.
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (abort) begin
      s_nxt.busy = 1'b0;
      s_nxt.cnt = CNT_ZERO;
    end else if (go && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = CNT_ZERO;
    end else if (s_r.busy) begin
      if (s_r.cnt == CNT_LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.code = code_in;
      end else begin
        s_nxt.cnt = s_r.cnt + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;
  assign code = s_r.code;

endmodule

/* bench/adcr_ctrl_monitor.sv */
// Assertion checker for the converter control block.
// Assumes it is bound to adcr_ctrl and sees only its ports.
module adcr_ctrl_monitor #(
  parameter int unsigned CONV_CYC = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [adcr_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [adcr_pkg::BUS_W-1:0] bus_rdata,
  input wire logic conv_end_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_LOW_PAD: assert property (bus_rd && bus_addr < 8 && bus_addr[0] |=> bus_rdata[5:0] == 6'h00)
    else $error("lower result byte has nonzero pad bits");
  AST_UNMAPPED: assert property (bus_rd && bus_addr > 9 |=> bus_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
  AST_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");
  AST_IRQ_CSR: assert property (bus_rd && bus_addr == 8 |=>
    (bus_rdata[7] & bus_rdata[6]) == $past(conv_end_irq))
    else $error("interrupt differs from flag and enable");
  AST_IRQ_FALL: assert property ($fell(conv_end_irq) |-> $past(bus_wr && bus_addr == 8))
    else $error("interrupt dropped without a control write");
  AST_IRQ_STEADY: assert property (conv_end_irq && !bus_wr |=> conv_end_irq)
    else $error("interrupt dropped while no write");
  AST_TRIG_PAD: assert property (bus_rd && bus_addr == 9 |=> bus_rdata[5:0] == 6'h00)
    else $error("trigger select has nonzero low bits");
  AST_RST_CLEAR: assert property (disable iff (1'b0) sys_rst |=> !conv_end_irq)
    else $error("interrupt high after reset");
endmodule

/* bench/adcr_front_model.sv */
// Behavioural analog front end presenting a code for the selected input.
// Assumes the bench holds salt steady while a conversion runs.
module adcr_front_model (
  input wire logic [adcr_pkg::CH_W-1:0] input_sel,
  input wire logic [6:0] salt,
  output logic [adcr_pkg::CODE_W-1:0] code_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The code carries the input number so a wrong mapping shows up.
  assign code_in = {salt, input_sel};
endmodule

/* bench/tb_adcr_ctrl.sv */
// Self-checking bench of the converter control block.
// Assumes a short conversion count and the behavioural front end.
module tb_adcr_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CYC = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [adcr_pkg::ADDR_W-1:0] bus_addr = 4'h0;
  logic [adcr_pkg::BUS_W-1:0] bus_wdata = 8'h00;
  logic [adcr_pkg::BUS_W-1:0] bus_rdata;
  logic tmr = 1'b0;
  logic ext_n = 1'b1;
  logic stby = 1'b0;
  logic [adcr_pkg::CODE_W-1:0] code_in;
  logic [adcr_pkg::CH_W-1:0] input_sel;
  logic conv_end_irq;
  logic [6:0] salt = 7'h00;
  logic [31:0] lfsr = 32'h0000_c282;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  adcr_ctrl #(.CONV_CYC(CYC)) u_dut (.clk(clk), .sys_rst(sys_rst), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .eight_bit_timer_trig(tmr), .ext_conv_trigger_n(ext_n), .standby_req(stby),
    .code_in(code_in), .input_sel(input_sel), .conv_end_irq(conv_end_irq));
  adcr_front_model u_front (.input_sel(input_sel), .salt(salt), .code_in(code_in));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask

  // A read notes its expected data, a write drives it.
  task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_rd = rd;
    bus_wr = ~rd;
    bus_addr = a;
    bus_wdata = d;
    if (rd) exp_q.push_back(d);
    @(negedge clk);
    bus_rd = 1'b0;
    bus_wr = 1'b0;
  endtask

  task automatic res(input int n, input logic [9:0] c);
    acc(1'b1, 4'(2 * n), c[9:2]);
    acc(1'b1, 4'(2 * n + 1), {c[1:0], 6'h00});
  endtask

  task automatic wait_irq(output int k);
    for (k = 0; k < 400 && conv_end_irq !== 1'b1; k++) @(negedge clk);
    if (conv_end_irq !== 1'b1) begin
      error_cnt++;
      test_done();
    end
  endtask

  always @(posedge clk) rd_seen <= bus_rd;
  always @(negedge clk) begin
    if (rd_seen) chk("bus_rdata", bus_rdata, exp_q.pop_front());
  end

  initial begin
    int n;
    int k;
    logic [2:0] ch;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    for (n = 0; n < 11; n++) acc(1'b1, n[3:0], 8'h00);
    $display("test reset done");
    for (n = 0; n < 8; n++) begin
      lfsr = nxt(lfsr);
      salt = lfsr[6:0];
      acc(1'b0, 4'h8, 8'h60 | n[7:0]);
      wait_irq(k);
      chk("conv_time", {7'h00, k >= CYC && k <= CYC + 4}, 8'h01);
      chk("input_sel", {5'h00, input_sel}, n[7:0]);
      res(n % 4, {salt, n[2:0]});
      acc(1'b0, 4'h8, (n[0] ? 8'hc0 : 8'h40) | n[7:0]);
      acc(1'b1, 4'h8, 8'hc0 | n[7:0]);
      acc(1'b0, 4'h8, 8'h40 | n[7:0]);
      @(negedge clk);
      chk("irq", {7'h00, conv_end_irq}, 8'h00);
    end
    $display("test single done");
    for (n = 0; n < 2; n++) begin
      ch = n[0] ? 3'h6 : 3'h3;
      lfsr = nxt(lfsr);
      salt = lfsr[6:0];
      acc(1'b0, 4'h8, {5'h0e, ch});
      wait_irq(k);
      chk("scan_time", {7'h00, k >= (int'(ch[1:0]) + 1) * CYC}, 8'h01);
      chk("input_sel", {5'h00, input_sel}, {5'h00, ch[2], 2'h0});
      acc(1'b1, 4'h8, {5'h1e, ch});
      acc(1'b0, 4'h8, {5'h0a, ch});
      acc(1'b1, 4'h8, {5'h0a, ch});
      for (k = 0; k <= int'(ch[1:0]); k++) res(k, {salt, ch[2], k[1:0]});
      acc(1'b0, 4'h8, 8'h00);
    end
    $display("test scan done");
    for (n = 0; n < 2; n++) begin
      lfsr = nxt(lfsr);
      salt = lfsr[6:0];
      acc(1'b0, 4'h9, n[0] ? 8'h80 : 8'h40);
      acc(1'b1, 4'h9, n[0] ? 8'h80 : 8'h40);
      acc(1'b0, 4'h8, 8'h41 + n[7:0]);
      if (n[0]) ext_n = 1'b0;
      else tmr = 1'b1;
      @(negedge clk);
      tmr = 1'b0;
      repeat (3) @(negedge clk);
      ext_n = 1'b1;
      wait_irq(k);
      res(1 + n, {salt, 3'(1 + n)});
      acc(1'b1, 4'h8, 8'hc1 + n[7:0]);
      acc(1'b0, 4'h8, 8'h00);
    end
    acc(1'b0, 4'h4, 8'hff);
    res(2, {salt, 3'h2});
    $display("test trigger done");
    acc(1'b0, 4'h8, 8'h33);
    @(negedge clk);
    stby = 1'b1;
    @(negedge clk);
    stby = 1'b0;
    acc(1'b1, 4'h8, 8'h13);
    $display("test standby done");
    repeat (4) @(negedge clk);
    test_done();
  end
endmodule

bind adcr_ctrl adcr_ctrl_monitor #(.CONV_CYC(CONV_CYC)) u_mon (.clk(clk), .sys_rst(sys_rst),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_rdata(bus_rdata),
  .conv_end_irq(conv_end_irq));
